// file: core/amd_pkg.sv
package amd_pkg;

	localparam int AMD_ADDR_W = 24;
	localparam int AMD_DATA_W = 16;

	// one flat byte range, fixed by the map
	localparam logic [AMD_ADDR_W-1:0] PFL_LO  = 24'h00_0000;
	localparam logic [AMD_ADDR_W-1:0] PFL_HI  = 24'h03_ffff;
	localparam logic [AMD_ADDR_W-1:0] DFL_LO  = 24'h0d_0000;
	localparam logic [AMD_ADDR_W-1:0] DFL_HI  = 24'h0d_1fff;
	localparam logic [AMD_ADDR_W-1:0] RAM_LO  = 24'h0e_0000;
	localparam logic [AMD_ADDR_W-1:0] RAM_HI  = 24'h0e_7fff;
	localparam logic [AMD_ADDR_W-1:0] CAN_LO  = 24'h0e_f000;
	localparam logic [AMD_ADDR_W-1:0] CAN_HI  = 24'h3f_ffff;
	localparam logic [AMD_ADDR_W-1:0] EXT1_LO = 24'h40_0000;
	localparam logic [AMD_ADDR_W-1:0] EXT1_HI = 24'h7f_ffff;
	localparam logic [AMD_ADDR_W-1:0] EXT2_LO = 24'h80_0000;
	localparam logic [AMD_ADDR_W-1:0] EXT2_HI = 24'hfe_ffff;
	localparam logic [AMD_ADDR_W-1:0] PER1_LO = 24'hff_f200;
	localparam logic [AMD_ADDR_W-1:0] PER1_HI = 24'hff_f5ff;
	localparam logic [AMD_ADDR_W-1:0] BREG_LO = 24'hff_f600;
	localparam logic [AMD_ADDR_W-1:0] BREG_HI = 24'hff_faff;
	localparam logic [AMD_ADDR_W-1:0] IOX_LO  = 24'hff_fb00;
	localparam logic [AMD_ADDR_W-1:0] IOX_HI  = 24'hff_fbff;
	localparam logic [AMD_ADDR_W-1:0] PER2_LO = 24'hff_fc00;
	localparam logic [AMD_ADDR_W-1:0] PER2_HI = 24'hff_ffff;

	typedef enum logic [3:0] {
		INTERNAL_BOOT_MODE        = 4'h1,
		EXTERNAL_BOOT_MODE        = 4'h2,
		DEVELOPMENT_MODE          = 4'h4,
		DEVELOPMENT_INTERNAL_MODE = 4'h8
	} amd_mode_t;

	typedef enum logic [8:0] {
		RG_NONE       = 9'h000,
		RG_PROG_FLASH = 9'h001,
		RG_DATA_FLASH = 9'h002,
		RG_SYS_RAM    = 9'h004,
		RG_CAN        = 9'h008,
		RG_EXT_Z1     = 9'h010,
		RG_EXT_Z2     = 9'h020,
		RG_PERIPH     = 9'h040,
		RG_BUS_REGS   = 9'h080,
		RG_IO_EXP     = 9'h100
	} amd_region_t;

	typedef enum logic [3:0] {
		ZN_NONE    = 4'h0,
		ZN_STATIC0 = 4'h1,
		ZN_STATIC1 = 4'h2,
		ZN_STATIC2 = 4'h4,
		ZN_IO      = 4'h8
	} amd_zone_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_ISSUE = 3'h2,
		ST_DONE  = 3'h4
	} amd_state_t;

	typedef struct packed {
		logic                  write;
		logic [AMD_ADDR_W-1:0] addr;
		logic [AMD_DATA_W-1:0] wdata;
	} amd_req_t;

	typedef struct packed {
		amd_region_t region;
		amd_zone_t   zone;
		logic        ext;
	} amd_dec_t;

	localparam amd_dec_t AMD_DEC_IDLE = '{region: RG_NONE, zone: ZN_NONE, ext: 1'b0};

	function automatic logic amd_in_range(input logic [AMD_ADDR_W-1:0] a,
		input logic [AMD_ADDR_W-1:0] lo, input logic [AMD_ADDR_W-1:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// gaps fall through as RG_NONE
	function automatic amd_dec_t amd_decode(input logic [AMD_ADDR_W-1:0] a,
		input amd_mode_t m);
		amd_dec_t d;
		d = AMD_DEC_IDLE;
		if (a <= PFL_HI) begin // [RQ3] [RQ4] [RQ13]
			d = '{region: RG_PROG_FLASH, zone: ZN_STATIC0, ext: (m == DEVELOPMENT_MODE)};
		end else if (amd_in_range(a, DFL_LO, DFL_HI)) begin // [RQ5] [RQ13]
			d = '{region: RG_DATA_FLASH, zone: ZN_STATIC0, ext: (m == DEVELOPMENT_MODE)};
		end else if (amd_in_range(a, RAM_LO, RAM_HI)) begin
			d.region = RG_SYS_RAM;
		end else if (amd_in_range(a, CAN_LO, CAN_HI)) begin // [RQ6]
			d.region = RG_CAN;
		end else if (amd_in_range(a, EXT1_LO, EXT1_HI)) begin // [RQ7]
			d = '{region: RG_EXT_Z1, zone: ZN_STATIC1, ext: 1'b1};
		end else if (amd_in_range(a, EXT2_LO, EXT2_HI)) begin // [RQ8]
			d = '{region: RG_EXT_Z2, zone: ZN_STATIC2, ext: 1'b1};
		end else if (amd_in_range(a, PER1_LO, PER1_HI) || amd_in_range(a, PER2_LO, PER2_HI)) begin
			d.region = RG_PERIPH; // [RQ9]
		end else if (amd_in_range(a, BREG_LO, BREG_HI)) begin // [RQ10]
			d.region = RG_BUS_REGS;
		end else if (amd_in_range(a, IOX_LO, IOX_HI)) begin // [RQ12]
			d = '{region: RG_IO_EXP, zone: ZN_IO, ext: 1'b0};
		end
		return d;
	endfunction

endpackage

// file: core/amd_mode_latch.sv
`timescale 1ns/100ps
`default_nettype none
module amd_mode_latch
	import amd_pkg::*;
(
	// clock and reset
	input  wire logic      ref_clk_i,
	input  wire logic      arst_n_i,
	// mode strap
	input  wire amd_mode_t mode_i,
	output var  amd_mode_t mode_o,
	output var  logic      valid_o
);

	amd_mode_t next_mode;
	logic      next_valid;

	// caught once after release; the strap may move later without effect
	always_comb begin
		next_mode  = mode_o;
		next_valid = 1'b1;
		if (!valid_o) begin
			unique case (mode_i)
				INTERNAL_BOOT_MODE,
				EXTERNAL_BOOT_MODE,
				DEVELOPMENT_MODE,
				DEVELOPMENT_INTERNAL_MODE: next_mode = mode_i;
				default:                   next_mode = INTERNAL_BOOT_MODE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_o  <= INTERNAL_BOOT_MODE;
			valid_o <= 1'b0;
		end else begin
			mode_o  <= next_mode;
			valid_o <= next_valid;
		end
	end

endmodule
`default_nettype wire

// file: core/amd_addr_decoder.sv
// How it works
// (RQ1) one flat 16M-byte range, 24-bit address
// (RQ2) masters never touch reserved or unlisted addresses
// (RQ3) 00_0000-03_FFFF program flash, static zone 0
// (RQ4) zone 0 external only in development mode
// (RQ5) 0D_0000-0D_1FFF data flash, static zone 0
// (RQ6) from 0E_F000 CAN buffers, no zone
// (RQ7) 40_0000-7F_FFFF external, static zone 1
// (RQ8) 80_0000-FE_FFFF external, static zone 2
// (RQ9) peripheral and port ranges, no zone
// (RQ10) FF_F600-FF_FAFF unit registers, no zone
// (RQ11) one zone code drives shared timing
// (RQ12) FF_FB00-FF_FBFF I/O expansion, I/O zone
// (RQ13) development disables flash; internal variant keeps it
// (RQ14) at most one select, none when reserved
// (RQ15) reserved: read zero, drop write, flag error
`timescale 1ns/100ps
`default_nettype none
module amd_addr_decoder
	import amd_pkg::*;
(
	// clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  arst_n_i,
	// operating mode strap
	input  wire amd_mode_t             mode_i,
	// core bus side
	input  wire logic                  req_valid_i,
	input  wire amd_req_t              req_i,
	output var  logic                  req_ready_o,
	output var  logic                  ack_o,
	output var  logic [AMD_DATA_W-1:0] rdata_o,
	// decode error flag
	input  wire logic                  dec_err_clr_i,
	output var  logic                  dec_err_o,
	// target side
	output var  amd_dec_t              tgt_dec_o,
	output var  logic                  tgt_rd_o,
	output var  logic                  tgt_wr_o,
	output var  logic [AMD_ADDR_W-1:0] tgt_addr_o,
	output var  logic [AMD_DATA_W-1:0] tgt_wdata_o,
	input  wire logic [AMD_DATA_W-1:0] tgt_rdata_i
);

	amd_mode_t             mode;
	logic                  mode_ok;
	amd_state_t            st;
	amd_state_t            next_st;
	amd_req_t              cur;
	amd_req_t              next_cur;
	amd_dec_t              next_dec;
	amd_dec_t              req_dec;
	logic                  next_rd;
	logic                  next_wr;
	logic                  next_ack;
	logic                  next_ready;
	logic                  next_err;
	logic [AMD_DATA_W-1:0] next_rdata;
	logic                  take;
	logic                  hit;

	amd_mode_latch u_mode (
		.ref_clk_i (ref_clk_i),
		.arst_n_i  (arst_n_i),
		.mode_i    (mode_i),
		.mode_o    (mode),
		.valid_o   (mode_ok)
	);

	// flat decode from the one linear address [RQ1] [RQ14]
	assign req_dec = amd_decode(req_i.addr, mode);
	assign hit     = (req_dec.region != RG_NONE);
	assign take    = req_valid_i & req_ready_o;

	// address and data held from the taken request
	assign tgt_addr_o  = cur.addr;
	assign tgt_wdata_o = cur.wdata;

	always_comb begin
		next_st    = st;
		next_cur   = cur;
		next_dec   = tgt_dec_o;
		next_rd    = 1'b0;
		next_wr    = 1'b0;
		next_ack   = 1'b0;
		next_rdata = rdata_o;
		next_err   = dec_err_o & ~dec_err_clr_i;
		unique case (st)
			ST_IDLE: begin
				if (take) begin
					next_st  = ST_ISSUE;
					next_cur = req_i;
					// one zone code per access selects the shared timing set [RQ11]
					next_dec = req_dec;
					// no strobe reaches a target for a reserved address [RQ15]
					next_rd  = hit & ~req_i.write;
					next_wr  = hit & req_i.write;
					// set wins over a clear in the same cycle [RQ15]
					if (!hit) begin
						next_err = 1'b1;
					end
				end
			end
			ST_ISSUE: begin
				next_st  = ST_DONE;
				next_ack = 1'b1;
				next_dec = AMD_DEC_IDLE;
				// reserved reads and all writes answer zero [RQ15]
				if ((tgt_dec_o.region != RG_NONE) && !cur.write) begin
					next_rdata = tgt_rdata_i;
				end else begin
					next_rdata = '0;
				end
			end
			ST_DONE: begin
				next_st = ST_IDLE;
			end
		endcase
		// nothing is taken before the mode strap is caught
		next_ready = (next_st == ST_IDLE) & mode_ok;
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st          <= ST_IDLE;
			cur         <= '0;
			tgt_dec_o   <= AMD_DEC_IDLE;
			tgt_rd_o    <= 1'b0;
			tgt_wr_o    <= 1'b0;
			ack_o       <= 1'b0;
			rdata_o     <= '0;
			req_ready_o <= 1'b0;
			dec_err_o   <= 1'b0;
		end else begin
			st          <= next_st;
			cur         <= next_cur;
			tgt_dec_o   <= next_dec;
			tgt_rd_o    <= next_rd;
			tgt_wr_o    <= next_wr;
			ack_o       <= next_ack;
			rdata_o     <= next_rdata;
			req_ready_o <= next_ready;
			dec_err_o   <= next_err;
		end
	end

	a_one_select: assert property ( // [RQ14]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		$onehot0(tgt_dec_o.region) && ((st == ST_ISSUE) || (tgt_dec_o == AMD_DEC_IDLE))
	) else $error("more than one region select or stale select");

	a_prog_flash_map: assert property ( // [RQ3]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && cur.addr <= PFL_HI)
		|-> (tgt_dec_o.region == RG_PROG_FLASH) && (tgt_dec_o.zone == ZN_STATIC0)
	) else $error("program flash range decoded wrongly");

	a_data_flash_map: assert property ( // [RQ5]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && amd_in_range(cur.addr, DFL_LO, DFL_HI))
		|-> (tgt_dec_o.region == RG_DATA_FLASH) && (tgt_dec_o.zone == ZN_STATIC0)
	) else $error("data flash range decoded wrongly");

	a_zone0_route: assert property ( // [RQ4] [RQ13]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && tgt_dec_o.zone == ZN_STATIC0)
		|-> (tgt_dec_o.ext == (mode == DEVELOPMENT_MODE))
	) else $error("static zone 0 routed to the wrong side");

	a_can_map: assert property ( // [RQ6]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && amd_in_range(cur.addr, CAN_LO, CAN_HI))
		|-> (tgt_dec_o.region == RG_CAN) && (tgt_dec_o.zone == ZN_NONE) && !tgt_dec_o.ext
	) else $error("can range decoded wrongly");

	a_ext_zone1: assert property ( // [RQ7]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && amd_in_range(cur.addr, EXT1_LO, EXT1_HI))
		|-> (tgt_dec_o.region == RG_EXT_Z1) && (tgt_dec_o.zone == ZN_STATIC1) && tgt_dec_o.ext
	) else $error("external zone 1 decoded wrongly");

	a_ext_zone2: assert property ( // [RQ8]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && amd_in_range(cur.addr, EXT2_LO, EXT2_HI))
		|-> (tgt_dec_o.region == RG_EXT_Z2) && (tgt_dec_o.zone == ZN_STATIC2) && tgt_dec_o.ext
	) else $error("external zone 2 decoded wrongly");

	a_periph_map: assert property ( // [RQ9]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && (amd_in_range(cur.addr, PER1_LO, PER1_HI)
			|| amd_in_range(cur.addr, PER2_LO, PER2_HI)))
		|-> (tgt_dec_o.region == RG_PERIPH) && (tgt_dec_o.zone == ZN_NONE)
	) else $error("peripheral range decoded wrongly");

	a_unit_regs_map: assert property ( // [RQ10]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && amd_in_range(cur.addr, BREG_LO, BREG_HI))
		|-> (tgt_dec_o.region == RG_BUS_REGS) && (tgt_dec_o.zone == ZN_NONE)
	) else $error("unit register range decoded wrongly");

	a_io_zone_map: assert property ( // [RQ12]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && amd_in_range(cur.addr, IOX_LO, IOX_HI))
		|-> (tgt_dec_o.region == RG_IO_EXP) && (tgt_dec_o.zone == ZN_IO)
	) else $error("io expansion range decoded wrongly");

	a_zone_stable: assert property ( // [RQ11]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(tgt_rd_o || tgt_wr_o) |-> (tgt_dec_o.zone == $past(req_dec.zone))
	) else $error("zone code does not follow the taken address");

	a_reserved_quiet: assert property ( // [RQ15]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && tgt_dec_o.region == RG_NONE)
		|-> (!tgt_rd_o && !tgt_wr_o && dec_err_o) ##1 (ack_o && rdata_o == '0)
	) else $error("reserved access reached a target or returned data");

	a_err_sticky: assert property ( // [RQ15]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(dec_err_o && !dec_err_clr_i) |=> dec_err_o
	) else $error("decode error flag dropped without a clear");

	a_access_timing: assert property ( // [RQ1]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		take |=> (st == ST_ISSUE && !ack_o && !req_ready_o)
			##1 (ack_o && !req_ready_o)
			##1 (!ack_o && req_ready_o)
	) else $error("access handshake off its cycle plan");

	a_strobe_mapped: assert property ( // [RQ15]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(tgt_rd_o || tgt_wr_o)
		|-> (st == ST_ISSUE) && (tgt_dec_o.region != RG_NONE) && (tgt_wr_o == cur.write)
			&& !(tgt_rd_o && tgt_wr_o)
	) else $error("target strobe outside a mapped access");

	a_read_data_path: assert property ( // [RQ1]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && tgt_rd_o) |=> ack_o && (rdata_o == $past(tgt_rdata_i))
	) else $error("read data not taken in the strobe cycle");

	// a reserved take beats a clear in the same cycle
	a_err_set_wins: assert property ( // [RQ15]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(take && !hit) |=> dec_err_o
	) else $error("reserved take did not set the error flag");

	a_err_clear: assert property ( // [RQ15]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(dec_err_clr_i && !(take && !hit)) |=> !dec_err_o
	) else $error("error flag not cleared");

	// a strap that moves after release must not reroute zone 0
	a_mode_frozen: assert property ( // [RQ13]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		mode_ok |=> $stable(mode)
	) else $error("mode changed after it was caught");

	a_ready_gated: assert property ( // [RQ13]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		!mode_ok |-> !req_ready_o
	) else $error("ready before the mode was caught");

	a_zone_region_pair: assert property ( // [RQ11]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE)
		|-> ((tgt_dec_o.zone == ZN_NONE)
			== (tgt_dec_o.region inside {RG_NONE, RG_SYS_RAM, RG_CAN, RG_PERIPH, RG_BUS_REGS}))
	) else $error("zone code does not match the region");

	a_ext_static_only: assert property ( // [RQ4]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		tgt_dec_o.ext |-> (tgt_dec_o.zone inside {ZN_STATIC0, ZN_STATIC1, ZN_STATIC2})
	) else $error("external route outside a static zone");

	a_reserved_no_zone: assert property ( // [RQ14]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && tgt_dec_o.region == RG_NONE)
		|-> (tgt_dec_o.zone == ZN_NONE) && !tgt_dec_o.ext
	) else $error("reserved access carries a zone or route");

	a_addr_follows: assert property ( // [RQ1]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(tgt_rd_o || tgt_wr_o)
		|-> (tgt_addr_o == $past(req_i.addr)) && (tgt_wdata_o == $past(req_i.wdata))
	) else $error("target address or data not from the taken request");

	a_ram_map: assert property ( // [RQ14]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st == ST_ISSUE && amd_in_range(cur.addr, RAM_LO, RAM_HI))
		|-> (tgt_dec_o.region == RG_SYS_RAM) && (tgt_dec_o.zone == ZN_NONE) && !tgt_dec_o.ext
	) else $error("system ram range decoded wrongly");

	a_idle_quiet: assert property ( // [RQ14]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st != ST_ISSUE) |-> !tgt_rd_o && !tgt_wr_o && (tgt_dec_o == AMD_DEC_IDLE)
	) else $error("target side active outside the issue cycle");

	a_ack_in_done: assert property ( // [RQ1]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		ack_o |-> (st == ST_DONE) && !req_ready_o
	) else $error("answer outside its cycle");

	// one access outstanding keeps the zone code unambiguous
	a_busy_not_ready: assert property ( // [RQ14]
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(st != ST_IDLE) |-> !req_ready_o
	) else $error("ready while an access is outstanding");

endmodule
`default_nettype wire

// file: tb/amd_tgt_model.sv
`timescale 1ns/100ps
`default_nettype none
module amd_tgt_model
	import amd_pkg::*;
(
	// clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  arst_n_i,
	// decoder target side
	input  wire logic                  tgt_rd_i,
	input  wire logic [AMD_ADDR_W-1:0] tgt_addr_i,
	output var  logic [AMD_DATA_W-1:0] tgt_rdata_o
);
	logic [AMD_DATA_W-1:0] junk;
	logic [AMD_DATA_W-1:0] next_junk;
	// off-cycle data flips every cycle so a late sample can look right only where the address ends in 0000 or FFFF
	always_comb begin
		next_junk = ~junk;
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			junk <= 16'h5a3c;
		end else begin
			junk <= next_junk;
		end
	end
	// data only in the strobe cycle, no wait states
	assign tgt_rdata_o = tgt_rd_i ? (tgt_addr_i[AMD_DATA_W-1:0] ^ 16'ha5c3) : junk;
endmodule
`default_nettype wire

// file: tb/address_map_decoder_test.sv
`timescale 1ns/100ps
`default_nettype none
module address_map_decoder_test;
	import amd_pkg::*;
	logic                  ref_clk_i;
	logic                  arst_n_i;
	amd_mode_t             mode_i;
	logic                  req_valid_i;
	amd_req_t              req_i;
	logic                  req_ready_o;
	logic                  ack_o;
	logic [AMD_DATA_W-1:0] rdata_o;
	logic                  dec_err_clr_i;
	logic                  dec_err_o;
	amd_dec_t              tgt_dec_o;
	logic                  tgt_rd_o;
	logic                  tgt_wr_o;
	logic [AMD_ADDR_W-1:0] tgt_addr_o;
	logic [AMD_DATA_W-1:0] tgt_wdata_o;
	logic [AMD_DATA_W-1:0] tgt_rdata_i;
	int                    num_errors;
	int                    n_tests;
	int                    cur_mode;
	logic                  err_exp;
	logic [31:0]           lfsr;
	int                    modes [5] = '{1, 2, 4, 8, 3};
	logic [23:0]           tbl [27] = '{24'h000000, 24'h03ffff, 24'h040000, 24'h0cffff,
		24'h0d0000, 24'h0d1fff, 24'h0d2000, 24'h0e0000, 24'h0e7fff, 24'h0e8000, 24'h0eefff,
		24'h0ef000, 24'h3fffff, 24'h400000, 24'h7fffff, 24'h800000, 24'hfeffff, 24'hff0000,
		24'hfff1ff, 24'hfff200, 24'hfff5ff, 24'hfff600, 24'hfffaff, 24'hfffb00, 24'hfffbff,
		24'hfffc00, 24'hffffff};

	amd_addr_decoder uut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .mode_i(mode_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .ack_o(ack_o),
		.rdata_o(rdata_o), .dec_err_clr_i(dec_err_clr_i), .dec_err_o(dec_err_o),
		.tgt_dec_o(tgt_dec_o), .tgt_rd_o(tgt_rd_o), .tgt_wr_o(tgt_wr_o),
		.tgt_addr_o(tgt_addr_o), .tgt_wdata_o(tgt_wdata_o), .tgt_rdata_i(tgt_rdata_i));
	amd_tgt_model u_tgt (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .tgt_rd_i(tgt_rd_o),
		.tgt_addr_i(tgt_addr_o), .tgt_rdata_o(tgt_rdata_i));

	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// reference map: {region, zone, ext}
	function automatic logic [13:0] ref_dec(input logic [31:0] a, input int m);
		int  r;
		int  z;
		logic e;
		r = 0;
		z = 0;
		e = 1'b0;
		if (a <= 32'h3ffff) begin
			r = 1; z = 1; e = (m == 4);
		end else if (a >= 32'hd0000 && a <= 32'hd1fff) begin
			r = 2; z = 1; e = (m == 4);
		end else if (a >= 32'he0000 && a <= 32'he7fff) begin
			r = 4;
		end else if (a >= 32'hef000 && a <= 32'h3fffff) begin
			r = 8;
		end else if (a >= 32'h400000 && a <= 32'h7fffff) begin
			r = 16; z = 2; e = 1'b1;
		end else if (a >= 32'h800000 && a <= 32'hfeffff) begin
			r = 32; z = 4; e = 1'b1;
		end else if ((a >= 32'hfff200 && a <= 32'hfff5ff) || a >= 32'hfffc00) begin
			r = 64;
		end else if (a >= 32'hfff600 && a <= 32'hfffaff) begin
			r = 128;
		end else if (a >= 32'hfffb00 && a <= 32'hfffbff) begin
			r = 256; z = 8;
		end
		return {r[8:0], z[3:0], e};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("tests=%0d errors=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one access from take to answer, entered and left at a falling edge
	task automatic access(input logic w, input logic [23:0] a, input logic [15:0] d);
		logic [13:0] x;
		logic        mp;
		int          k;
		x = ref_dec({8'h00, a}, cur_mode);
		mp = (x[13:5] != 9'h000);
		k = 0;
		req_valid_i = 1'b1;
		req_i = '{write: w, addr: a, wdata: d};
		while (req_ready_o !== 1'b1 && k < 20) begin
			@(negedge ref_clk_i);
			k++;
		end
		@(negedge ref_clk_i);
		req_valid_i = 1'b0;
		if (!mp) err_exp = 1'b1;
		chk(tgt_dec_o, x);
		chk({tgt_rd_o, tgt_wr_o, ack_o, req_ready_o}, {!w && mp, w && mp, 2'b00});
		chk(tgt_addr_o, a);
		chk(tgt_wdata_o, d);
		chk(dec_err_o, err_exp);
		@(negedge ref_clk_i);
		chk({ack_o, tgt_rd_o, tgt_wr_o, tgt_dec_o}, {3'b100, 14'h0000});
		chk(rdata_o, (mp && !w) ? (a[15:0] ^ 16'ha5c3) : 16'h0000);
	endtask

	initial begin
		#1000000;
		num_errors++;
		print_verdict();
	end

	initial begin
		logic [13:0] x;
		arst_n_i = 1'b0;
		mode_i = INTERNAL_BOOT_MODE;
		req_valid_i = 1'b0;
		req_i = '0;
		dec_err_clr_i = 1'b0;
		num_errors = 0;
		n_tests = 0;
		lfsr = 32'hd185;
		foreach (modes[j]) begin
			@(negedge ref_clk_i);
			arst_n_i = 1'b0;
			cur_mode = modes[j];
			mode_i = amd_mode_t'(cur_mode);
			err_exp = 1'b0;
			repeat (16) @(negedge ref_clk_i);
			arst_n_i = 1'b1;
			repeat (4) @(negedge ref_clk_i);
			// strap was caught at release; a later change must not matter
			mode_i = (cur_mode == 4) ? INTERNAL_BOOT_MODE : DEVELOPMENT_MODE;
			foreach (tbl[i]) begin
				lfsr = nxt(lfsr);
				access(1'b0, tbl[i], lfsr[15:0]);
				access(1'b1, tbl[i], lfsr[31:16]);
			end
			chk(dec_err_o, 1'b1);
			dec_err_clr_i = 1'b1;
			@(negedge ref_clk_i);
			chk(dec_err_o, 1'b0);
			// a reserved take in a clearing cycle still sets the flag
			access(1'b0, tbl[2], lfsr[15:0]);
			dec_err_clr_i = 1'b0;
			err_exp = 1'b0;
			chk(dec_err_o, 1'b0);
			// random traffic stays on mapped addresses
			repeat (40) begin
				lfsr = nxt(lfsr);
				x = ref_dec({8'h00, lfsr[23:0]}, cur_mode);
				if (x[13:5] != 9'h000) access(lfsr[24], lfsr[23:0], lfsr[31:16]);
			end
		end
		print_verdict();
	end
endmodule
`default_nettype wire
